// ---- hcfp_pkg.sv ----
package hcfp_pkg;

  // ********************************
  // report layout
  // ********************************
  localparam int HCFP_RPT_LEN = 24;
  localparam int HCFP_PAY_LEN = 22;
  localparam int HCFP_OFS_CMD = 0;
  localparam int HCFP_OFS_LEN = 1;
  localparam int HCFP_OFS_PAY = 2;
  localparam logic [4:0] HCFP_RPT_LAST = 5'h17;
  localparam logic [7:0] HCFP_PAY_MAX = 8'h16;

  // ********************************
  // commands and result codes
  // ********************************
  localparam logic [7:0] HCFP_CMD_GET_PROP = 8'h00;
  localparam logic [7:0] HCFP_CMD_SET_PROP = 8'h01;
  localparam logic [7:0] HCFP_RES_SUCCESS = 8'h00;
  localparam logic [7:0] HCFP_RES_FAILURE = 8'h01;
  localparam logic [7:0] HCFP_RES_BAD_PARAM = 8'h02;
  localparam int HCFP_RES_SPECIFIC_BIT = 7;
  localparam logic [23:0] HCFP_STRIPE_READER_FORWARD_PREFIX = 24'h4d5352;
  localparam logic [7:0] HCFP_PREFIX_LEN = 8'h03;

  // ********************************
  // property store
  // ********************************
  localparam int HCFP_NUM_PROP = 16;
  localparam logic [7:0] HCFP_NUM_PROP_B = 8'h10;
  localparam logic [7:0] HCFP_PROP_RST = 8'h00;

  // ********************************
  // keyboard report
  // ********************************
  localparam logic [7:0] HCFP_MOD_FIRST = 8'he0;
  localparam logic [7:0] HCFP_MOD_LAST = 8'he7;
  localparam logic [7:0] HCFP_KEY_MAX = 8'h65;
  localparam logic [7:0] HCFP_MOD_LSHIFT = 8'h02;
  localparam int HCFP_LED_BITS = 5;
  localparam int HCFP_LED_PAD = 3;
  localparam int HCFP_LED_CAPS = 1;
  localparam logic [7:0] HCFP_USE_A = 8'h04;
  localparam logic [7:0] HCFP_USE_ONE = 8'h1e;
  localparam logic [7:0] HCFP_USE_ZERO = 8'h27;
  localparam logic [7:0] HCFP_USE_ENTER = 8'h28;
  localparam logic [7:0] HCFP_USE_SPACE = 8'h2c;
  localparam logic [7:0] HCFP_USE_MINUS = 8'h2d;
  localparam logic [7:0] HCFP_USE_EQUAL = 8'h2e;
  localparam logic [7:0] HCFP_USE_SEMI = 8'h33;
  localparam logic [7:0] HCFP_USE_SLASH = 8'h38;
  localparam logic [7:0] HCFP_USE_FIVE = 8'h22;
  localparam logic [7:0] HCFP_USE_SIX = 8'h23;

  // ********************************
  // report descriptor
  // ********************************
  localparam logic [15:0] HCFP_VENDOR_PAGE = 16'hff00;
  localparam logic [7:0] HCFP_CMD_USAGE = 8'h20;
  localparam logic [7:0] HCFP_FEAT_COUNT = 8'h18;
  localparam int HCFP_DESC_LEN = 76;
  localparam logic [7:0] HCFP_DESC_LEN_B = 8'h4c;
  localparam logic [8*HCFP_DESC_LEN-1:0] HCFP_DESC = {
    8'h05, 8'h01, 8'h09, 8'h06, 8'ha1, 8'h01, 8'h05, 8'h07, 8'h19, 8'he0, 8'h29, 8'he7,
    8'h15, 8'h00, 8'h25, 8'h01, 8'h75, 8'h01, 8'h95, 8'h08, 8'h81, 8'h02, 8'h95, 8'h01,
    8'h75, 8'h08, 8'h81, 8'h03, 8'h95, 8'h05, 8'h75, 8'h01, 8'h05, 8'h08, 8'h19, 8'h01,
    8'h29, 8'h05, 8'h91, 8'h02, 8'h95, 8'h01, 8'h75, 8'h03, 8'h91, 8'h03, 8'h95, 8'h06,
    8'h75, 8'h08, 8'h15, 8'h00, 8'h25, 8'h66, 8'h05, 8'h07, 8'h19, 8'h00, 8'h29, 8'h66,
    8'h81, 8'h00, 8'h26, 8'hff, 8'h00, 8'h06, 8'h00, 8'hff, 8'h09, HCFP_CMD_USAGE,
    8'h95, HCFP_FEAT_COUNT, 8'hb2, 8'h02, 8'h01, 8'hc0};

  typedef logic [7:0] hcfp_byte_t;

  typedef struct packed {
    logic [7:0] modifiers;
    logic [7:0] reserved;
    logic [47:0] keys;
  } hcfp_kbd_rpt_s;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] len;
    logic [7:0] data;
  } hcfp_resp_s;

endpackage

// ---- hcfp_kbd.sv ----
`timescale 1ns/1ps
module hcfp_kbd (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic char_valid_i,
  input wire logic [7:0] char_i,
  output logic char_ready_o,
  output logic rpt_valid_o,
  output hcfp_pkg::hcfp_kbd_rpt_s rpt_o,
  input wire logic rpt_ready_i,
  input wire logic led_wr_valid_i,
  input wire logic [7:0] led_wr_data_i,
  output logic [hcfp_pkg::HCFP_LED_BITS-1:0] led_o
);

  // ********************************
  // ascii to key usage
  // ********************************
  // returns {shift, usage}; usage zero means the character is dropped
  function automatic logic [8:0] key_of(input logic [7:0] c);
    logic [8:0] r;
    r = 9'h000;
    if (c >= 8'h61 && c <= 8'h7a)
      r = {1'b1, 8'(hcfp_pkg::HCFP_USE_A + (c - 8'h61))};
    else if (c >= 8'h41 && c <= 8'h5a)
      r = {1'b1, 8'(hcfp_pkg::HCFP_USE_A + (c - 8'h41))};
    else if (c >= 8'h31 && c <= 8'h39)
      r = {1'b0, 8'(hcfp_pkg::HCFP_USE_ONE + (c - 8'h31))};
    else
    begin
      case (c)
        8'h30: r = {1'b0, hcfp_pkg::HCFP_USE_ZERO};
        8'h0d: r = {1'b0, hcfp_pkg::HCFP_USE_ENTER};
        8'h20: r = {1'b0, hcfp_pkg::HCFP_USE_SPACE};
        8'h2d: r = {1'b0, hcfp_pkg::HCFP_USE_MINUS};
        8'h3d: r = {1'b0, hcfp_pkg::HCFP_USE_EQUAL};
        8'h3b: r = {1'b0, hcfp_pkg::HCFP_USE_SEMI};
        8'h2f: r = {1'b0, hcfp_pkg::HCFP_USE_SLASH};
        8'h3f: r = {1'b1, hcfp_pkg::HCFP_USE_SLASH};
        8'h25: r = {1'b1, hcfp_pkg::HCFP_USE_FIVE};
        8'h5e: r = {1'b1, hcfp_pkg::HCFP_USE_SIX};
        default: r = 9'h000;
      endcase
    end
    return r;
  endfunction

  typedef enum logic [2:0] {
    KB_IDLE = 3'b001,
    KB_PRESS = 3'b010,
    KB_RELEASE = 3'b100
  } hcfp_kb_state_e;

  hcfp_kb_state_e state_ff;
  hcfp_kb_state_e nxt_state;

  logic [8:0] key;
  logic is_letter;
  logic take_char;
  logic caps_on;
  logic rpt_done;
  hcfp_pkg::hcfp_kbd_rpt_s press_rpt;

  assign key = key_of(char_i);
  assign is_letter = (char_i >= 8'h41 && char_i <= 8'h5a) || (char_i >= 8'h61 && char_i <= 8'h7a);
  // caps lamp is output report bit 1 (lamp usage 2), not bit 0
  assign caps_on = led_o[hcfp_pkg::HCFP_LED_CAPS];
  assign take_char = char_ready_o && char_valid_i && (key[7:0] != 8'h00);
  assign rpt_done = rpt_valid_o && rpt_ready_i;
  // RULE16 uppercase despite caps
  // with caps lock on, shift on a letter would give lower case, so shift is dropped
  assign press_rpt.modifiers = (key[8] && !(is_letter && caps_on)) ? hcfp_pkg::HCFP_MOD_LSHIFT
                               : 8'h00;
  // RULE13 reserved byte constant
  assign press_rpt.reserved = 8'h00;
  assign press_rpt.keys = {40'h0000000000, key[7:0]};

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      KB_IDLE: if (take_char) nxt_state = KB_PRESS;
      KB_PRESS: if (rpt_done) nxt_state = KB_RELEASE;
      KB_RELEASE: if (rpt_done) nxt_state = KB_IDLE;
      default: nxt_state = KB_IDLE;
    endcase
  end

  // RULE15 keystroke reports
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= KB_IDLE;
      rpt_valid_o <= 1'b0;
      rpt_o <= '0;
      char_ready_o <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      rpt_valid_o <= (nxt_state != KB_IDLE);
      if (take_char)
        rpt_o <= press_rpt;
      else if (state_ff == KB_PRESS && rpt_done)
        rpt_o <= '0;
      char_ready_o <= (nxt_state == KB_IDLE);
    end
  end

  // RULE14 lamp bits kept, padding ignored
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      led_o <= '0;
    else if (led_wr_valid_i)
      led_o <= led_wr_data_i[hcfp_pkg::HCFP_LED_BITS-1:0];
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_upper;
    take_char && is_letter && !caps_on |=> rpt_o.modifiers == hcfp_pkg::HCFP_MOD_LSHIFT;
  endproperty
  a_upper: assert property (p_upper) else $error("letter sent without shift"); // RULE16

  property p_caps;
    take_char && is_letter && caps_on |=> rpt_o.modifiers == 8'h00;
  endproperty
  a_caps: assert property (p_caps) else $error("shift sent with caps lock on"); // RULE16

  property p_release;
    rpt_valid_o && rpt_ready_i && state_ff == KB_PRESS |=> rpt_valid_o && rpt_o.keys == '0;
  endproperty
  a_release: assert property (p_release) else $error("key release missing"); // RULE15

  property p_rpt_shape;
    rpt_valid_o |-> rpt_o.reserved == 8'h00 && rpt_o.keys[7:0] <= hcfp_pkg::HCFP_KEY_MAX;
  endproperty
  a_rpt_shape: assert property (p_rpt_shape) else $error("bad report shape"); // RULE13

  property p_led;
    led_wr_valid_i |=> led_o == $past(led_wr_data_i[4:0]);
  endproperty
  a_led: assert property (p_led) else $error("lamp state not taken"); // RULE14

endmodule

// ---- hcfp_top.sv ----
`timescale 1ns/1ps
// What this block does
// RULE1: requests arrive as set-report feature data, responses leave on get-report.
// RULE2: status stage is refused with nak until the command has finished.
// RULE3: request byte 0 command, byte 1 length, 22 payload bytes from byte 2.
// RULE4: response byte 0 result code, byte 1 length, payload after.
// RULE5: only length payload bytes are meaningful; the rest are ignored.
// RULE6: host pads unused payload bytes with zero.
// RULE7: local result codes keep top bit clear; set codes are command specific.
// RULE8: generic codes: 0 success, 1 failure, 2 bad parameter.
// RULE9: command 0x00 reads a property, command 0x01 writes one.
// RULE10: payload starting with reader prefix is forwarded to the card engine.
// RULE11: command message is usage 0x20 on vendor page 0xff00, feature data.
// RULE12: feature report is 0x18 byte fields, max 255, buffered bytes.
// RULE13: keyboard report: eight modifier bits, pad byte, six key bytes 0..101; the descriptor declares the key range as 0..102 (0x66).
// RULE14: lamp output report: five lamp bits then three pad bits.
// RULE15: card and check text goes out as keystroke reports.
// RULE16: characters are sent uppercase whatever caps lock says.
// RULE17: property id at payload 0; value follows on write, from 0 on read.
// RULE18: unknown command or oversize length answers bad parameter, empty payload.
module hcfp_top (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic FEAT_WR_VALID_I,
  input wire logic [7:0] FEAT_WR_DATA_I,
  input wire logic FEAT_WR_LAST_I,
  output logic STATUS_NAK_O,
  input wire logic FEAT_RD_REQ_I,
  output logic FEAT_RD_VALID_O,
  output logic [7:0] FEAT_RD_DATA_O,
  output logic FEAT_RD_LAST_O,
  output logic FWD_VALID_O,
  output logic [7:0] FWD_DATA_O,
  output logic FWD_LAST_O,
  input wire logic FWD_READY_I,
  input wire logic FWD_DONE_I,
  input wire logic [7:0] FWD_RESULT_I,
  input wire logic CHAR_VALID_I,
  input wire logic [7:0] CHAR_I,
  output logic CHAR_READY_O,
  output logic KBD_VALID_O,
  output hcfp_pkg::hcfp_kbd_rpt_s KBD_REPORT_O,
  input wire logic KBD_READY_I,
  input wire logic LED_WR_VALID_I,
  input wire logic [7:0] LED_WR_DATA_I,
  output logic [hcfp_pkg::HCFP_LED_BITS-1:0] LED_STATE_O,
  input wire logic [6:0] DESC_ADDR_I,
  output logic [7:0] DESC_DATA_O
);

  // ********************************
  // helpers
  // ********************************
  function automatic logic [7:0] desc_byte(input logic [6:0] a);
    logic [7:0] r;
    r = 8'h00;
    if ({1'b0, a} < hcfp_pkg::HCFP_DESC_LEN_B)
      r = hcfp_pkg::HCFP_DESC[8*(hcfp_pkg::HCFP_DESC_LEN-1-int'(a)) +: 8];
    return r;
  endfunction

  // ********************************
  // state
  // ********************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RECV = 6'b000010,
    ST_EXEC = 6'b000100,
    ST_FWD = 6'b001000,
    ST_WAIT = 6'b010000,
    ST_RESP = 6'b100000
  } hcfp_state_e;

  hcfp_state_e state_ff;
  hcfp_state_e nxt_state;

  hcfp_pkg::hcfp_byte_t req_ff [0:hcfp_pkg::HCFP_RPT_LEN-1];
  hcfp_pkg::hcfp_byte_t prop_ff [0:hcfp_pkg::HCFP_NUM_PROP-1];
  hcfp_pkg::hcfp_resp_s resp_ff;
  hcfp_pkg::hcfp_resp_s nxt_resp;
  logic [4:0] wr_idx_ff;
  logic [4:0] rd_idx_ff;
  logic [4:0] fwd_idx_ff;

  // ********************************
  // request decode
  // ********************************
  logic [7:0] req_cmd;
  logic [7:0] req_len;
  logic [7:0] prop_id;
  logic len_bad;
  logic is_fwd;
  logic prop_ok;
  logic get_ok;
  logic set_ok;
  logic wr_take;
  logic wr_end;
  logic rd_start;
  logic fwd_load;
  logic fwd_end;
  logic [7:0] rd_byte;
  logic [4:0] rd_out_idx;

  // RULE3 fixed byte positions
  assign req_cmd = req_ff[hcfp_pkg::HCFP_OFS_CMD];
  assign req_len = req_ff[hcfp_pkg::HCFP_OFS_LEN];
  // RULE17 property id at payload start
  assign prop_id = req_ff[hcfp_pkg::HCFP_OFS_PAY];
  // RULE18 oversize length
  assign len_bad = req_len > hcfp_pkg::HCFP_PAY_MAX;
  // RULE10 reader prefix detect
  assign is_fwd = !len_bad && req_len >= hcfp_pkg::HCFP_PREFIX_LEN &&
                  {req_ff[2], req_ff[3], req_ff[4]} == hcfp_pkg::HCFP_STRIPE_READER_FORWARD_PREFIX;
  assign prop_ok = prop_id < hcfp_pkg::HCFP_NUM_PROP_B;
  // RULE5 fields beyond length ignored
  assign get_ok = req_cmd == hcfp_pkg::HCFP_CMD_GET_PROP && req_len >= 8'h01 && prop_ok;
  assign set_ok = req_cmd == hcfp_pkg::HCFP_CMD_SET_PROP && req_len >= 8'h02 && prop_ok;

  // RULE1 set-report data stage
  assign wr_take = FEAT_WR_VALID_I && (state_ff == ST_IDLE || state_ff == ST_RECV);
  assign wr_end = wr_take && FEAT_WR_LAST_I;
  // RULE1 get-report data stage
  assign rd_start = FEAT_RD_REQ_I && state_ff == ST_IDLE && !FEAT_WR_VALID_I;
  assign fwd_end = FWD_VALID_O && FWD_READY_I && FWD_LAST_O;
  assign fwd_load = state_ff == ST_FWD && (!FWD_VALID_O || FWD_READY_I) &&
                    !(FWD_VALID_O && FWD_LAST_O);

  // RULE4 response layout, zero padded
  assign rd_byte = rd_idx_ff == 5'h00 ? resp_ff.code :
                   rd_idx_ff == 5'h01 ? resp_ff.len :
                   (rd_idx_ff == 5'h02 && resp_ff.len != 8'h00) ? resp_ff.data : 8'h00;
  assign rd_out_idx = rd_idx_ff - 5'h01;

  // RULE8 generic outcomes
  // RULE18 unknown command refused
  always_comb
  begin
    nxt_resp = resp_ff;
    if (state_ff == ST_EXEC && !is_fwd)
    begin
      nxt_resp.len = 8'h00;
      nxt_resp.data = 8'h00;
      nxt_resp.code = hcfp_pkg::HCFP_RES_BAD_PARAM;
      if (!len_bad && (get_ok || set_ok))
        nxt_resp.code = hcfp_pkg::HCFP_RES_SUCCESS;
      // RULE17 read value at payload 0
      if (!len_bad && get_ok)
      begin
        nxt_resp.len = 8'h01;
        nxt_resp.data = prop_ff[prop_id[3:0]];
      end
    end
    else if (state_ff == ST_WAIT && FWD_DONE_I)
    begin
      // RULE7 engine codes may be command specific
      nxt_resp.code = FWD_RESULT_I;
      nxt_resp.len = 8'h00;
      nxt_resp.data = 8'h00;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (wr_end)
          nxt_state = ST_EXEC;
        else if (wr_take)
          nxt_state = ST_RECV;
        else if (rd_start)
          nxt_state = ST_RESP;
      end
      ST_RECV: if (wr_end) nxt_state = ST_EXEC;
      ST_EXEC: nxt_state = is_fwd ? ST_FWD : ST_IDLE;
      ST_FWD: if (fwd_end) nxt_state = ST_WAIT;
      ST_WAIT: if (FWD_DONE_I) nxt_state = ST_IDLE;
      ST_RESP: if (rd_idx_ff == hcfp_pkg::HCFP_RPT_LAST) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ********************************
  // registers
  // ********************************
  // RULE2 nak until command done
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      state_ff <= ST_IDLE;
      resp_ff <= '0;
      STATUS_NAK_O <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      resp_ff <= nxt_resp;
      STATUS_NAK_O <= nxt_state == ST_EXEC || nxt_state == ST_FWD || nxt_state == ST_WAIT;
    end
  end

  // extra bytes past the fixed report length overwrite the last byte, as the write index holds at 23
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      wr_idx_ff <= 5'h00;
    else if (wr_end)
      wr_idx_ff <= 5'h00;
    else if (wr_take && wr_idx_ff != hcfp_pkg::HCFP_RPT_LAST)
      wr_idx_ff <= wr_idx_ff + 5'h01;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (wr_take)
      req_ff[wr_idx_ff] <= FEAT_WR_DATA_I;
  end

  // RULE9 property write
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      for (int i = 0; i < hcfp_pkg::HCFP_NUM_PROP; i++)
        prop_ff[i] <= hcfp_pkg::HCFP_PROP_RST;
    end
    else if (state_ff == ST_EXEC && !is_fwd && !len_bad && set_ok)
      prop_ff[prop_id[3:0]] <= req_ff[hcfp_pkg::HCFP_OFS_PAY + 1];
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      rd_idx_ff <= 5'h00;
      FEAT_RD_VALID_O <= 1'b0;
      FEAT_RD_DATA_O <= 8'h00;
      FEAT_RD_LAST_O <= 1'b0;
    end
    else
    begin
      FEAT_RD_VALID_O <= state_ff == ST_RESP;
      FEAT_RD_DATA_O <= state_ff == ST_RESP ? rd_byte : 8'h00;
      FEAT_RD_LAST_O <= state_ff == ST_RESP && rd_idx_ff == hcfp_pkg::HCFP_RPT_LAST;
      rd_idx_ff <= state_ff == ST_RESP ? rd_idx_ff + 5'h01 : 5'h00;
    end
  end

  // RULE10 whole report to card engine
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      fwd_idx_ff <= 5'h00;
      FWD_VALID_O <= 1'b0;
      FWD_DATA_O <= 8'h00;
      FWD_LAST_O <= 1'b0;
    end
    else if (fwd_load)
    begin
      FWD_VALID_O <= 1'b1;
      FWD_DATA_O <= req_ff[fwd_idx_ff];
      FWD_LAST_O <= fwd_idx_ff == hcfp_pkg::HCFP_RPT_LAST;
      fwd_idx_ff <= fwd_idx_ff + 5'h01;
    end
    else if (fwd_end || state_ff != ST_FWD)
    begin
      FWD_VALID_O <= 1'b0;
      FWD_LAST_O <= 1'b0;
      fwd_idx_ff <= 5'h00;
    end
  end

  // RULE11 vendor command usage
  // RULE12 feature report item
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      DESC_DATA_O <= 8'h00;
    else
      DESC_DATA_O <= desc_byte(DESC_ADDR_I);
  end

  // ********************************
  // keyboard path
  // ********************************
  // RULE15 text as keystrokes
  hcfp_kbd i_hcfp_kbd (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .char_valid_i(CHAR_VALID_I),
    .char_i(CHAR_I),
    .char_ready_o(CHAR_READY_O),
    .rpt_valid_o(KBD_VALID_O),
    .rpt_o(KBD_REPORT_O),
    .rpt_ready_i(KBD_READY_I),
    .led_wr_valid_i(LED_WR_VALID_I),
    .led_wr_data_i(LED_WR_DATA_I),
    .led_o(LED_STATE_O)
  );

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_hdr;
    FEAT_RD_DATA_O == resp_ff.code ##1 FEAT_RD_DATA_O == resp_ff.len;
  endsequence

  property p_nak;
    wr_end |=> STATUS_NAK_O;
  endproperty
  a_nak: assert property (p_nak) else $error("status not refused after request"); // RULE2

  property p_nak_clear;
    state_ff == ST_EXEC && !is_fwd |=> !STATUS_NAK_O ##0 state_ff == ST_IDLE;
  endproperty
  a_nak_clear: assert property (p_nak_clear) else $error("nak held after completion"); // RULE2

  property p_hdr;
    $rose(FEAT_RD_VALID_O) |-> s_hdr;
  endproperty
  a_hdr: assert property (p_hdr) else $error("response header misplaced"); // RULE4

  property p_rd_len;
    $rose(FEAT_RD_VALID_O) |-> !FEAT_RD_LAST_O ##23 FEAT_RD_LAST_O ##1 !FEAT_RD_VALID_O;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("response not 24 bytes"); // RULE3

  property p_pad;
    FEAT_RD_VALID_O && {3'b000, rd_out_idx} >= 8'h02 + resp_ff.len |-> FEAT_RD_DATA_O == 8'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("payload past length not zero"); // RULE5

  property p_bad;
    state_ff == ST_EXEC && len_bad |=> resp_ff.code == hcfp_pkg::HCFP_RES_BAD_PARAM &&
      resp_ff.len == 8'h00;
  endproperty
  a_bad: assert property (p_bad) else $error("oversize length not refused"); // RULE18

  property p_generic;
    state_ff == ST_EXEC && !is_fwd |=> !resp_ff.code[hcfp_pkg::HCFP_RES_SPECIFIC_BIT];
  endproperty
  a_generic: assert property (p_generic) else $error("local code not generic"); // RULE7

  property p_get;
    state_ff == ST_EXEC && !is_fwd && !len_bad && get_ok |=> resp_ff.len == 8'h01 &&
      resp_ff.code == hcfp_pkg::HCFP_RES_SUCCESS && resp_ff.data == $past(prop_ff[prop_id[3:0]]);
  endproperty
  a_get: assert property (p_get) else $error("property read wrong"); // RULE9

  property p_fwd;
    state_ff == ST_EXEC && is_fwd |=> state_ff == ST_FWD ##1 FWD_VALID_O && FWD_DATA_O == req_cmd;
  endproperty
  a_fwd: assert property (p_fwd) else $error("prefixed request not forwarded"); // RULE10

endmodule

// ---- hcfp_engine_model.sv ----
`timescale 1ns/1ps
// ****
// card engine model
// ****
module hcfp_engine_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic last_i,
  output logic ready_o,
  output logic done_o,
  output logic [7:0] result_o
);
  logic [7:0] rx [24];
  int cnt = 0;
  int wait_n = 0;
  initial
  begin
    ready_o = 1'b0;
    done_o = 1'b0;
    result_o = 8'h7a;
  end
  always @(posedge clk_i)
  begin
    if (valid_i && ready_o && cnt < 24)
    begin
      rx[cnt] = data_i;
      cnt++;
      if (last_i)
        wait_n = 5;
    end
  end
  // ready every other cycle, to stall the stream
  // result with top bit set
  always @(negedge clk_i)
  begin
    ready_o <= rst_n_i && !ready_o;
    done_o <= (wait_n == 1);
    result_o <= (wait_n == 1) ? 8'h85 : ~result_o;
    if (wait_n > 0)
      wait_n--;
  end
endmodule

// ---- hcfp_top_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end \
  end
module hcfp_top_tb;
  logic MCLK_I, RST_N_I, FEAT_WR_VALID_I, FEAT_WR_LAST_I, FEAT_RD_REQ_I, FWD_READY_I;
  logic FWD_DONE_I, CHAR_VALID_I, KBD_READY_I, LED_WR_VALID_I, STATUS_NAK_O;
  logic FEAT_RD_VALID_O, FEAT_RD_LAST_O, FWD_VALID_O, FWD_LAST_O, CHAR_READY_O, KBD_VALID_O;
  logic [7:0] FEAT_WR_DATA_I, FWD_RESULT_I, CHAR_I, LED_WR_DATA_I;
  logic [7:0] FEAT_RD_DATA_O, FWD_DATA_O, DESC_DATA_O;
  logic [6:0] DESC_ADDR_I;
  logic [hcfp_pkg::HCFP_LED_BITS-1:0] LED_STATE_O;
  hcfp_pkg::hcfp_kbd_rpt_s KBD_REPORT_O;
  logic [7:0] rq [24];
  logic [7:0] rs [24];
  int num_errors = 0;
  int samples_checked = 0;
  hcfp_top i_hcfp_top (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
    .FEAT_WR_VALID_I(FEAT_WR_VALID_I), .FEAT_WR_DATA_I(FEAT_WR_DATA_I),
    .FEAT_WR_LAST_I(FEAT_WR_LAST_I), .STATUS_NAK_O(STATUS_NAK_O),
    .FEAT_RD_REQ_I(FEAT_RD_REQ_I), .FEAT_RD_VALID_O(FEAT_RD_VALID_O),
    .FEAT_RD_DATA_O(FEAT_RD_DATA_O), .FEAT_RD_LAST_O(FEAT_RD_LAST_O),
    .FWD_VALID_O(FWD_VALID_O), .FWD_DATA_O(FWD_DATA_O), .FWD_LAST_O(FWD_LAST_O),
    .FWD_READY_I(FWD_READY_I), .FWD_DONE_I(FWD_DONE_I), .FWD_RESULT_I(FWD_RESULT_I),
    .CHAR_VALID_I(CHAR_VALID_I), .CHAR_I(CHAR_I), .CHAR_READY_O(CHAR_READY_O),
    .KBD_VALID_O(KBD_VALID_O), .KBD_REPORT_O(KBD_REPORT_O), .KBD_READY_I(KBD_READY_I),
    .LED_WR_VALID_I(LED_WR_VALID_I), .LED_WR_DATA_I(LED_WR_DATA_I),
    .LED_STATE_O(LED_STATE_O), .DESC_ADDR_I(DESC_ADDR_I), .DESC_DATA_O(DESC_DATA_O));
  hcfp_engine_model i_hcfp_engine_model (.clk_i(MCLK_I), .rst_n_i(RST_N_I),
    .valid_i(FWD_VALID_O), .data_i(FWD_DATA_O), .last_i(FWD_LAST_O),
    .ready_o(FWD_READY_I), .done_o(FWD_DONE_I), .result_o(FWD_RESULT_I));
  initial
  begin
    MCLK_I = 1'b0;
    forever #5 MCLK_I = ~MCLK_I;
  end
  // ****
  // shared tasks
  // ****
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic req(input logic [7:0] c, l, p0, p1, p2);
    foreach (rq[i]) rq[i] = 8'h00;
    rq[0] = c;
    rq[1] = l;
    rq[2] = p0;
    rq[3] = p1;
    rq[4] = p2;
  endtask
  task automatic send(output int n);
    n = 0;
    for (int i = 0; i < 24; i++)
    begin
      @(negedge MCLK_I);
      FEAT_WR_VALID_I = 1'b1;
      FEAT_WR_DATA_I = rq[i];
      FEAT_WR_LAST_I = (i == 23);
    end
    @(negedge MCLK_I);
    FEAT_WR_VALID_I = 1'b0;
    FEAT_WR_LAST_I = 1'b0;
    for (int k = 0; k < 4 && STATUS_NAK_O !== 1'b1; k++) @(negedge MCLK_I);
    while (STATUS_NAK_O === 1'b1 && n < 300)
    begin
      n++;
      @(negedge MCLK_I);
    end
  endtask
  task automatic get(input logic [7:0] c, l, d);
    @(negedge MCLK_I);
    FEAT_RD_REQ_I = 1'b1;
    @(negedge MCLK_I);
    FEAT_RD_REQ_I = 1'b0;
    for (int k = 0; k < 4 && FEAT_RD_VALID_O !== 1'b1; k++) @(negedge MCLK_I);
    for (int i = 0; i < 24; i++)
    begin
      rs[i] = FEAT_RD_DATA_O;
      `CHK("rd_last", (i == 23), FEAT_RD_LAST_O)
      @(negedge MCLK_I);
    end
    `CHK("rd_end", 1'b0, FEAT_RD_VALID_O)
    `CHK("code", c, rs[0])
    `CHK("len", l, rs[1])
    `CHK("data", d, rs[2])
    for (int i = 3; i < 24; i++) `CHK("pad", 8'h00, rs[i])
  endtask
  task automatic key(input logic [7:0] c, m, k);
    @(negedge MCLK_I);
    CHAR_VALID_I = 1'b1;
    CHAR_I = c;
    @(negedge MCLK_I);
    CHAR_VALID_I = 1'b0;
    for (int j = 0; j < 5 && KBD_VALID_O !== 1'b1; j++) @(negedge MCLK_I);
    @(negedge MCLK_I);
    `CHK("mods", m, KBD_REPORT_O.modifiers)
    `CHK("pad", 8'h00, KBD_REPORT_O.reserved)
    `CHK("key", {40'h0, k}, KBD_REPORT_O.keys)
    KBD_READY_I = 1'b1;
    @(negedge MCLK_I);
    for (int j = 0; j < 5 && KBD_VALID_O !== 1'b1; j++) @(negedge MCLK_I);
    `CHK("release", 64'h0, KBD_REPORT_O)
    `CHK("kvalid", 1'b1, KBD_VALID_O)
    @(negedge MCLK_I);
    KBD_READY_I = 1'b0;
    `CHK("kidle", 1'b0, KBD_VALID_O)
  endtask
  task automatic led(input logic [7:0] d, input logic [4:0] e);
    @(negedge MCLK_I);
    LED_WR_VALID_I = 1'b1;
    LED_WR_DATA_I = d;
    @(negedge MCLK_I);
    LED_WR_VALID_I = 1'b0;
    `CHK("lamps", e, LED_STATE_O)
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    logic [7:0] pv;
    logic f1, f2;
    `CHK("nak", 1'b0, STATUS_NAK_O)
    `CHK("ready", 1'b1, CHAR_READY_O)
    pv = 8'h00;
    f1 = 1'b0;
    f2 = 1'b0;
    for (int a = 0; a < 76; a++)
    begin
      @(negedge MCLK_I);
      DESC_ADDR_I = 7'(a);
      @(negedge MCLK_I);
      f1 |= (pv == 8'h09 && DESC_DATA_O == 8'h20);
      f2 |= (pv == 8'h95 && DESC_DATA_O == 8'h18);
      pv = DESC_DATA_O;
    end
    `CHK("usage", 1'b1, f1)
    `CHK("count", 1'b1, f2)
    DESC_ADDR_I = 7'h64;
    repeat (2) @(negedge MCLK_I);
    `CHK("beyond", 8'h00, DESC_DATA_O)
    $display("test reset done");
  endtask
  task automatic t_prop();
    int n;
    req(8'h01, 8'h02, 8'h03, 8'ha5, 8'h00);
    send(n);
    `CHK("nak_len", 1, n)
    get(8'h00, 8'h00, 8'h00);
    req(8'h01, 8'h02, 8'h0f, 8'h5a, 8'h00);
    send(n);
    req(8'h00, 8'h01, 8'h03, 8'h00, 8'h00);
    send(n);
    get(8'h00, 8'h01, 8'ha5);
    get(8'h00, 8'h01, 8'ha5);
    req(8'h00, 8'h01, 8'h0f, 8'h00, 8'h00);
    send(n);
    get(8'h00, 8'h01, 8'h5a);
    $display("test prop done");
  endtask
  task automatic t_bad();
    int n;
    logic [7:0] bt [4][3] = '{'{8'h07, 8'h00, 8'h00}, '{8'h00, 8'h17, 8'h00},
      '{8'h00, 8'h01, 8'h10}, '{8'h01, 8'h02, 8'h10}};
    for (int i = 0; i < 4; i++)
    begin
      req(bt[i][0], bt[i][1], bt[i][2], 8'h00, 8'h00);
      send(n);
      get(8'h02, 8'h00, 8'h00);
    end
    $display("test bad done");
  endtask
  task automatic t_fwd();
    int n;
    req(8'h01, 8'h03, 8'h4d, 8'h53, 8'h52);
    send(n);
    `CHK("fwd_nak", 1'b1, n > 30)
    for (int i = 0; i < 24; i++) `CHK("fwd", rq[i], i_hcfp_engine_model.rx[i])
    get(8'h85, 8'h00, 8'h00);
    $display("test fwd done");
  endtask
  task automatic t_kbd();
    led(8'hff, 5'h1f);
    led(8'h00, 5'h00);
    key(8'h61, 8'h02, 8'h04);
    key(8'h5a, 8'h02, 8'h1d);
    key(8'h31, 8'h00, 8'h1e);
    key(8'h3f, 8'h02, 8'h38);
    led(8'h02, 5'h02);
    key(8'h61, 8'h00, 8'h04);
    $display("test kbd done");
  endtask
  initial
  begin
    #100000;
    num_errors++;
    test_done();
  end
  initial
  begin
    {RST_N_I, FEAT_WR_VALID_I, FEAT_WR_LAST_I, FEAT_RD_REQ_I} = 4'h0;
    {CHAR_VALID_I, KBD_READY_I, LED_WR_VALID_I} = 3'h0;
    FEAT_WR_DATA_I = 8'h00;
    CHAR_I = 8'h00;
    LED_WR_DATA_I = 8'h00;
    DESC_ADDR_I = 7'h00;
    repeat (5) @(negedge MCLK_I);
    RST_N_I = 1'b1;
    repeat (2) @(negedge MCLK_I);
    t_reset();
    t_prop();
    t_bad();
    t_fwd();
    t_kbd();
    test_done();
  end
endmodule
